// ### src/sixc_ctrl.sv
// six-step square-wave commutation with dual duty paths and apb registers
// assumes 8-bit level codes from external converters, hall pins asynchronous,
// and an outside sine generator that takes the gates while sine_active is high
//
// Operation
// (R1) pwm carrier is the system clock divided by 64.
// (R2) primary duty comes from speed pin or speed register.
// (R3) secondary duty is amplified torque reference minus sensed current.
// (R4) both paths act together; the lower one sets the duty.
// (R5) below 0.5 V is zero duty, 4.5 V is full duty, linear between.
// (R6) system holds an unused path at full scale.
// (R7) start-up always uses square drive with the dual-pwm pattern.
// (R8) stand-alone switches to sine drive once running conditions allow.
// (R9) host may pick dual-pwm, chop-then-hold or sine after start.
// (R10) each of six valid hall codes selects exactly one step.
// (R11) dual-pwm: one phase chops two steps, two lows alternate.
// (R12) dual-pwm never holds a high side on continuously; at full duty the code keeps it on.
// (R13) chopping high side off turns same-phase low side on.
// (R14) chop-then-hold: odd steps hold high on, another low chops.
// (R15) chop-then-hold keeps the dual-pwm current directions per step.
// (R16) serial force bits override the automatic sine/square choice.
// (R17) direction select reverses the applied step order.
// (R18) high and low of one phase never overlap; programmable dead time.
// (R19) hall code all ones or zeros turns gates off and flags error.

`timescale 1ns/10ps

module sixc_ctrl
   import sixc_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // motor side pins
   input wire logic [2:0] hall_pin,
   input wire logic direction_select,
   input wire logic [7:0] speed_ref_pin,
   input wire logic [7:0] torque_reference_pin,
   input wire logic [7:0] current_sense_pin,
   // angle predictor agreement, same clock
   input wire logic angle_hit,
   // gate drive, index 0 = u, 1 = v, 2 = w
   output logic [2:0] gate_hi,
   output logic [2:0] gate_lo,
   // status
   output logic sine_active,
   output logic pwm_carrier,
   output logic irq
);

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   // converter codes are assumed to change slowly; a torn code lasts one cycle
   localparam int SW = 28;
   logic [SW-1:0] sync1_reg, sync2_reg;
   always_ff @(posedge clk) begin
      if (srst) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end else begin
         sync1_reg <= {hall_pin, direction_select, speed_ref_pin,
                       torque_reference_pin, current_sense_pin};
         sync2_reg <= sync1_reg;
      end
   end
   wire [2:0] hall_s = sync2_reg[27:25];
   wire dir_s = sync2_reg[24];
   wire [7:0] speed_pin_s = sync2_reg[23:16];
   wire [7:0] torque_pin_s = sync2_reg[15:8];
   wire [7:0] isense_s = sync2_reg[7:0];

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   logic [2:0] ctrl_reg;
   logic [1:0] vmod_reg;
   logic [1:0] pwmmode_reg;
   logic [7:0] speed_reg, torque_reference_register, dead_reg;
   logic [3:0] gain_reg;
   logic [IRQ_W-1:0] irq_stat_reg, irq_en_reg, irq_ev;
   logic [31:0] prdata_reg, rd_mux;

   wire setup = psel & ~penable;
   wire wr = psel & penable & pwrite;
   wire hit_ctrl = paddr == OFS_CTRL;
   wire hit_vmod = paddr == OFS_VMOD;
   wire hit_pwmm = paddr == OFS_PWMMODE;
   wire hit_speed = paddr == OFS_SPEED;
   wire hit_torque = paddr == OFS_TORQUE;
   wire hit_gain = paddr == OFS_GAIN;
   wire hit_dead = paddr == OFS_DEAD;
   wire hit_stat = paddr == OFS_STATUS;
   wire hit_istat = paddr == OFS_IRQ_STAT;
   wire hit_iclr = paddr == OFS_IRQ_CLR;
   wire hit_ien = paddr == OFS_IRQ_EN;
   wire hit_any = hit_ctrl | hit_vmod | hit_pwmm | hit_speed | hit_torque | hit_gain
                  | hit_dead | hit_stat | hit_istat | hit_iclr | hit_ien;

   always_ff @(posedge clk) begin
      if (srst) begin
         ctrl_reg <= CTRL_RST;
         vmod_reg <= VMOD_RST;
         pwmmode_reg <= PWMMODE_RST;
         speed_reg <= SPEED_RST;
         torque_reference_register <= TORQUE_RST;
         gain_reg <= GAIN_RST;
         dead_reg <= DEAD_RST;
         irq_en_reg <= IRQ_EN_RST;
      end else if (wr) begin
         if (hit_ctrl) ctrl_reg <= pwdata[2:0];
         if (hit_vmod) vmod_reg <= pwdata[7:6];
         if (hit_pwmm) pwmmode_reg <= {pwdata[7], pwdata[0]};
         if (hit_speed) speed_reg <= pwdata[7:0];
         if (hit_torque) torque_reference_register <= pwdata[7:0];
         if (hit_gain) gain_reg <= pwdata[3:0];
         if (hit_dead) dead_reg <= pwdata[7:0];
         if (hit_ien) irq_en_reg <= pwdata[IRQ_W-1:0];
      end
   end

   wire serial = ctrl_reg[CTRL_SERIAL];
   wire force_sine_select = vmod_reg[VMOD_FORCE_SINE - 6];
   wire sine_enable = vmod_reg[VMOD_SINE_EN - 6];
   wire square_mode_force = pwmmode_reg[1];
   wire chop_sel = pwmmode_reg[PWMMODE_CHOP_HOLD];

   // ---------------------------------------------------------------
   // duty selection
   // ---------------------------------------------------------------
   wire [7:0] primary_lvl = ctrl_reg[CTRL_SPEED_SRC] ? speed_reg : speed_pin_s; // R2
   wire [7:0] tref_lvl = ctrl_reg[CTRL_TORQUE_SRC] ? torque_reference_register
                                                   : torque_pin_s;
   // error amplifier: gain times difference, clipped to the level range
   wire signed [8:0] err_diff = $signed({1'b0, tref_lvl}) - $signed({1'b0, isense_s});
   wire signed [13:0] err_amp = err_diff * $signed({1'b0, gain_reg});
   wire [7:0] secondary_lvl = err_amp < 0 ? 8'h00 :
                              err_amp > 14'sd255 ? 8'hFF : err_amp[7:0]; // R3
   wire [7:0] eff_lvl = secondary_lvl < primary_lvl ? secondary_lvl : primary_lvl; // R4
   wire [7:0] lvl_ofs = eff_lvl - LVL_ZERO;
   wire [13:0] lvl_scaled = 14'({6'h00, lvl_ofs} * PWM_DIV);
   wire [DUTY_W-1:0] duty_cmd = eff_lvl <= LVL_ZERO ? '0 :
                                eff_lvl >= LVL_FULL ? DUTY_W'(PWM_DIV) :
                                DUTY_W'(lvl_scaled / {6'h00, LVL_SPAN}); // R5

   // ---------------------------------------------------------------
   // carrier
   // ---------------------------------------------------------------
   logic [5:0] carrier_reg;
   logic [DUTY_W-1:0] duty_reg;
   wire period_end = carrier_reg == 6'(PWM_DIV - 1);
   // duty only changes at a period boundary so no pulse is cut short
   always_ff @(posedge clk) begin
      if (srst) begin
         carrier_reg <= '0;
         duty_reg <= '0;
      end else begin
         carrier_reg <= carrier_reg + 6'd1; // R1
         if (period_end) duty_reg <= duty_cmd;
      end
   end
   wire pwm_on = {1'b0, carrier_reg} < duty_reg;
   assign pwm_carrier = carrier_reg[5];

   // ---------------------------------------------------------------
   // hall decode and step
   // ---------------------------------------------------------------
   logic [2:0] step_raw;
   always_comb begin
      unique case (hall_s) // R10
         3'b101: step_raw = 3'd1;
         3'b100: step_raw = 3'd2;
         3'b110: step_raw = 3'd3;
         3'b010: step_raw = 3'd4;
         3'b011: step_raw = 3'd5;
         3'b001: step_raw = 3'd6;
         default: step_raw = 3'd0;
      endcase
   end
   wire hall_err = step_raw == 3'd0; // R19
   wire [2:0] step = (dir_s && !hall_err) ? 3'd7 - step_raw : step_raw; // R17

   // high and low phase per step; odd steps continue the previous high phase
   logic [1:0] hi_ph, lo_ph;
   always_comb begin
      unique case (step) // R11 R15
         3'd1: begin
            hi_ph = 2'd2;
            lo_ph = 2'd1;
         end
         3'd2: begin
            hi_ph = 2'd0;
            lo_ph = 2'd1;
         end
         3'd3: begin
            hi_ph = 2'd0;
            lo_ph = 2'd2;
         end
         3'd4: begin
            hi_ph = 2'd1;
            lo_ph = 2'd2;
         end
         3'd5: begin
            hi_ph = 2'd1;
            lo_ph = 2'd0;
         end
         3'd6: begin
            hi_ph = 2'd2;
            lo_ph = 2'd0;
         end
         default: begin
            hi_ph = 2'd0;
            lo_ph = 2'd0;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // drive mode
   // ---------------------------------------------------------------
   logic [2:0] step_reg;
   logic started_reg;
   sixc_mode_t mode;
   wire step_ev = !hall_err && step != step_reg;
   wire auto_sine = angle_hit & started_reg & (duty_reg != '0); // R8
   logic sine_sel;
   always_comb begin
      sine_sel = auto_sine;
      if (serial) begin // R16
         if (square_mode_force) sine_sel = 1'b0;
         else if (force_sine_select) sine_sel = sine_enable;
      end
   end
   // until the first commutation only dual-pwm square drive is allowed
   assign mode = (sine_sel && started_reg) ? MODE_SINE :
                 (serial && chop_sel && started_reg) ? MODE_CHOP : MODE_DUAL; // R7 R9
   assign sine_active = mode == MODE_SINE;

   always_ff @(posedge clk) begin
      if (srst) begin
         step_reg <= '0;
         started_reg <= 1'b0;
      end else begin
         if (!hall_err) step_reg <= step;
         if (step_ev && step_reg != 3'd0) started_reg <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // gate demand per phase, then dead time
   // ---------------------------------------------------------------
   wire hold = mode == MODE_CHOP && step[0]; // R14
   wire square = mode != MODE_SINE && !hall_err; // R19
   logic [2:0] want_hi, want_lo;

   genvar p;
   generate
      for (p = 0; p < 3; p++) begin : g_phase
         logic hi_q, lo_q;
         logic [7:0] hi_off_reg, lo_off_reg;
         wire is_hi = square && hi_ph == 2'(p);
         wire is_lo = square && lo_ph == 2'(p);
         // high side chops unless held or at full duty, where pwm_on stays high and dual-pwm keeps it on despite R12
         assign want_hi[p] = is_hi && (hold || pwm_on); // R12 R14
         assign want_lo[p] = (is_lo && (!hold || pwm_on))
                             || (is_hi && !hold && !pwm_on); // R13
         always_ff @(posedge clk) begin
            if (srst) begin
               hi_q <= 1'b0;
               lo_q <= 1'b0;
               hi_off_reg <= CNT_SAT;
               lo_off_reg <= CNT_SAT;
            end else begin
               // a side turns on only after the other has been off dead_reg cycles
               hi_q <= want_hi[p] && !lo_q && !want_lo[p] && lo_off_reg >= dead_reg; // R18
               lo_q <= want_lo[p] && !hi_q && !want_hi[p] && hi_off_reg >= dead_reg; // R18
               hi_off_reg <= hi_q ? 8'h00 : (hi_off_reg == CNT_SAT ? CNT_SAT
                                                                  : hi_off_reg + 8'd1);
               lo_off_reg <= lo_q ? 8'h00 : (lo_off_reg == CNT_SAT ? CNT_SAT
                                                                  : lo_off_reg + 8'd1);
            end
         end
         assign gate_hi[p] = hi_q;
         assign gate_lo[p] = lo_q;
      end
   endgenerate

   // ---------------------------------------------------------------
   // interrupts
   // ---------------------------------------------------------------
   logic sine_q_reg, herr_q_reg;
   wire [IRQ_W-1:0] irq_clr = (wr && hit_iclr) ? pwdata[IRQ_W-1:0] : '0;
   assign irq_ev[IRQ_HALL_ERR] = hall_err && !herr_q_reg; // R19
   assign irq_ev[IRQ_STEP] = step_ev && step_reg != 3'd0;
   assign irq_ev[IRQ_SINE] = sine_active != sine_q_reg;
   // a new event in the clearing cycle survives the clear
   always_ff @(posedge clk) begin
      if (srst) begin
         irq_stat_reg <= '0;
         sine_q_reg <= 1'b0;
         // flushing synchronisers read 000, so reset counts as faulted
         herr_q_reg <= 1'b1;
      end else begin
         irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_ev;
         sine_q_reg <= sine_active;
         herr_q_reg <= hall_err;
      end
   end
   assign irq = |(irq_stat_reg & irq_en_reg);

   // ---------------------------------------------------------------
   // read path: data captured in the setup cycle, zero wait states
   // ---------------------------------------------------------------
   assign rd_mux = hit_ctrl ? {29'h0, ctrl_reg} :
                   hit_vmod ? {24'h0, vmod_reg, 6'h00} :
                   hit_pwmm ? {24'h0, pwmmode_reg[1], 6'h00, pwmmode_reg[0]} :
                   hit_speed ? {24'h0, speed_reg} :
                   hit_torque ? {24'h0, torque_reference_register} :
                   hit_gain ? {28'h0, gain_reg} :
                   hit_dead ? {24'h0, dead_reg} :
                   hit_stat ? {18'h0, mode, duty_reg, hall_err, step_reg} :
                   hit_istat ? {29'h0, irq_stat_reg} :
                   hit_ien ? {29'h0, irq_en_reg} : 32'h0000_0000;
   always_ff @(posedge clk) begin
      if (srst) prdata_reg <= 32'h0000_0000;
      else if (setup) prdata_reg <= rd_mux;
   end
   assign prdata = prdata_reg;
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~hit_any;

endmodule

// ### src/sixc_pkg.sv
// six-step commutation and duty control: shared constants and types
// assumes 8-bit level codes spanning 0 V to ADC_FS_MV, and an APB register window

package sixc_pkg;

   // ---------------------------------------------------------------
   // register byte offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_VMOD = 8'h04;
   localparam logic [7:0] OFS_PWMMODE = 8'h08;
   localparam logic [7:0] OFS_SPEED = 8'h0C;
   localparam logic [7:0] OFS_TORQUE = 8'h10;
   localparam logic [7:0] OFS_GAIN = 8'h14;
   localparam logic [7:0] OFS_DEAD = 8'h18;
   localparam logic [7:0] OFS_STATUS = 8'h1C;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h20;
   localparam logic [7:0] OFS_IRQ_CLR = 8'h24;
   localparam logic [7:0] OFS_IRQ_EN = 8'h28;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int CTRL_SPEED_SRC = 0;
   localparam int CTRL_TORQUE_SRC = 1;
   localparam int CTRL_SERIAL = 2;
   localparam int VMOD_FORCE_SINE = 7;
   localparam int VMOD_SINE_EN = 6;
   localparam int PWMMODE_SQUARE_FORCE = 7;
   localparam int PWMMODE_CHOP_HOLD = 0;
   localparam int IRQ_HALL_ERR = 0;
   localparam int IRQ_STEP = 1;
   localparam int IRQ_SINE = 2;
   localparam int IRQ_W = 3;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [2:0] CTRL_RST = 3'h0;
   localparam logic [1:0] VMOD_RST = 2'h0;
   localparam logic [1:0] PWMMODE_RST = 2'h0;
   localparam logic [7:0] SPEED_RST = 8'h00;
   localparam logic [7:0] TORQUE_RST = 8'hFF;
   localparam logic [3:0] GAIN_RST = 4'h1;
   localparam logic [7:0] DEAD_RST = 8'h0A;
   localparam logic [IRQ_W-1:0] IRQ_EN_RST = 3'h0;

   // ---------------------------------------------------------------
   // carrier and level scaling
   // ---------------------------------------------------------------
   localparam int PWM_DIV = 64;
   localparam int DUTY_W = 7;
   localparam int ADC_FS_MV = 5000;
   localparam int ZERO_MV = 500;
   localparam int FULL_MV = 4500;
   localparam logic [7:0] LVL_ZERO = 8'((ZERO_MV * 255 + ADC_FS_MV / 2) / ADC_FS_MV);
   localparam logic [7:0] LVL_FULL = 8'((FULL_MV * 255 + ADC_FS_MV / 2) / ADC_FS_MV);
   localparam logic [7:0] LVL_SPAN = 8'(LVL_FULL - LVL_ZERO);
   localparam logic [7:0] CNT_SAT = 8'hFF;

   // drive scheme, one-hot
   typedef enum logic [2:0] {
      MODE_DUAL = 3'b001,
      MODE_CHOP = 3'b010,
      MODE_SINE = 3'b100
   } sixc_mode_t;

endpackage

// ### dv/sixc_ctrl_asserts.sv
// checker of sixc_ctrl port behaviour: gates, hall fault, carrier, apb error
// assumes one clock domain and the reset dead time of ten cycles
`timescale 1ns/10ps

module sixc_ctrl_asserts
   import sixc_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic [7:0] paddr,
   input wire logic pslverr,
   // motor side
   input wire logic [2:0] hall_pin,
   input wire logic [2:0] gate_hi,
   input wire logic [2:0] gate_lo,
   input wire logic sine_active,
   input wire logic pwm_carrier,
   input wire logic irq
);
   // ----------------
   // carrier half period in clocks
   // ----------------
   logic [6:0] car_cnt;
   logic car_seen;
   always_ff @(posedge clk) begin
      if (srst || $changed(pwm_carrier)) begin
         car_cnt <= 7'h00;
      end else begin
         car_cnt <= car_cnt + 7'h01;
      end
      // first half after reset may be cut short, so it is skipped
      car_seen <= !srst && (car_seen || $changed(pwm_carrier));
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);
   sequence s_hall_bad;
      (hall_pin == 3'h0 || hall_pin == 3'h7) [*4];
   endsequence
   sequence s_sine_on;
      sine_active [*2];
   endsequence
   property p_rst_quiet;
      $fell(srst) |-> gate_hi == 3'h0 && gate_lo == 3'h0 && !irq && !sine_active;
   endproperty
   a_rst_quiet: assert property (p_rst_quiet) else $error("outputs active after reset");
   property p_hall_off;
      s_hall_bad |-> gate_hi == 3'h0 && gate_lo == 3'h0;
   endproperty
   a_hall_off: assert property (p_hall_off) else $error("gates on with faulty hall code");
   property p_no_overlap;
      (gate_hi & gate_lo) == 3'h0;
   endproperty
   a_no_overlap: assert property (p_no_overlap) else $error("high and low on together");
   property p_dead_hi;
      ((gate_hi & ~$past(gate_hi)) & ($past(gate_lo) | $past(gate_lo, 2))) == 3'h0;
   endproperty
   a_dead_hi: assert property (p_dead_hi) else $error("high side on without gap");
   property p_dead_lo;
      ((gate_lo & ~$past(gate_lo)) & ($past(gate_hi) | $past(gate_hi, 2))) == 3'h0;
   endproperty
   a_dead_lo: assert property (p_dead_lo) else $error("low side on without gap");
   property p_one_high;
      $onehot0(gate_hi);
   endproperty
   a_one_high: assert property (p_one_high) else $error("two high sides on");
   property p_sine_off;
      s_sine_on |-> gate_hi == 3'h0 && gate_lo == 3'h0;
   endproperty
   a_sine_off: assert property (p_sine_off) else $error("square gates on in sine drive");
   property p_carrier;
      $changed(pwm_carrier) && car_seen |-> car_cnt == 7'h1F;
   endproperty
   a_carrier: assert property (p_carrier) else $error("carrier half period not 32");
   property p_unmapped;
      psel && penable && paddr > OFS_IRQ_EN |-> pslverr;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("no error on unmapped address");
endmodule

bind sixc_ctrl sixc_ctrl_asserts sixc_ctrl_asserts_inst (.clk(clk), .srst(srst),
   .psel(psel), .penable(penable), .paddr(paddr), .pslverr(pslverr), .hall_pin(hall_pin),
   .gate_hi(gate_hi), .gate_lo(gate_lo), .sine_active(sine_active),
   .pwm_carrier(pwm_carrier), .irq(irq));

// ### dv/sixc_motor_model.sv
// hall sensors and sense lines on the motor side of sixc_ctrl
// assumes the bench names a sensor step; 0 and 7 give the faulty codes
`timescale 1ns/10ps

module sixc_motor_model
   import sixc_pkg::*;
(
   // clock
   input wire logic clk,
   // bench commands
   input wire logic [2:0] step_cmd,
   input wire logic [7:0] isense_cmd,
   // sensor outputs
   output logic [2:0] hall_pin,
   output logic [7:0] torque_reference_pin,
   output logic [7:0] current_sense_pin
);
   localparam logic [2:0] HALL_TAB [8] = '{3'h0, 3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1, 3'h7};
   always_ff @(posedge clk) begin
      hall_pin <= HALL_TAB[step_cmd];
      current_sense_pin <= isense_cmd;
   end
   // unused torque path parked at full scale so it never limits speed
   assign torque_reference_pin = LVL_FULL;
endmodule

// ### dv/tb.sv
// self-checking bench of sixc_ctrl: registers, steps, duty, drive choice, irq
// assumes the motor model on the hall side and the bound checker
`timescale 1ns/10ps

module tb
   import sixc_pkg::*;
();
   logic clk, srst, psel, penable, pwrite, direction_select, angle_hit, psamp;
   logic pready, pslverr, sine_active, pwm_carrier, irq;
   logic [7:0] paddr, speed_ref_pin, torque_reference_pin, current_sense_pin, isense_cmd;
   logic [31:0] pwdata, prdata;
   logic [2:0] hall_pin, gate_hi, gate_lo, step_cmd;
   logic [63:0] rq[$];
   logic [7:0] pq[$];
   int n_errors, cmp_count, s, v;
   integer seed;
   localparam int HI_IDX [7] = '{0, 2, 0, 0, 1, 1, 2};
   localparam int LO_IDX [7] = '{0, 1, 1, 2, 2, 0, 0};
   localparam int LVLS [7] = '{0, 26, 27, 128, 229, 230, 255};
   localparam int TQ_T [3] = '{200, 200, 200};
   localparam int TQ_I [3] = '{72, 72, 230};
   localparam int TQ_G [3] = '{1, 2, 1};
   localparam logic [31:0] SN_V [3] = '{32'hC0, 32'h80, 32'hC0};
   localparam logic [31:0] SN_P [3] = '{32'h0, 32'h0, 32'h80};
   localparam logic [31:0] SN_E [3] = '{32'h2000, 32'h0800, 32'h0800};
   localparam logic [39:0] RST_TAB [9] = '{40'h00_0000_0000, 40'h04_0000_0000,
      40'h08_0000_0000, 40'h0C_0000_0000, 40'h10_0000_00FF, 40'h14_0000_0001,
      40'h18_0000_000A, 40'h28_0000_0000, 40'h40_0000_0000};

   sixc_ctrl sixc_ctrl_inst (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .hall_pin(hall_pin), .direction_select(direction_select),
      .speed_ref_pin(speed_ref_pin), .torque_reference_pin(torque_reference_pin),
      .current_sense_pin(current_sense_pin), .angle_hit(angle_hit), .gate_hi(gate_hi),
      .gate_lo(gate_lo), .sine_active(sine_active), .pwm_carrier(pwm_carrier), .irq(irq));
   sixc_motor_model sixc_motor_model_inst (.clk(clk), .step_cmd(step_cmd),
      .isense_cmd(isense_cmd), .hall_pin(hall_pin),
      .torque_reference_pin(torque_reference_pin), .current_sense_pin(current_sense_pin));

   always #2.5 clk = ~clk;

   // ----------------
   // bus, pin sampling and comparison
   // ----------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run;
      $display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr_en;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      rq.push_back({m, e});
      apb(1'b0, a, 32'h0);
   endtask
   // pins: {sine_active, irq, gate_hi, gate_lo}
   task automatic pin(input logic [7:0] e);
      pq.push_back(e);
      psamp <= 1'b1;
      @(posedge clk);
      psamp <= 1'b0;
      @(posedge clk);
   endtask
   function automatic logic [7:0] gexp(input int st, input logic full, input logic chop);
      logic [2:0] h, l;
      h = 3'(1 << HI_IDX[st]);
      l = 3'(1 << LO_IDX[st]);
      if (chop && st[0]) return {2'h0, h, full ? l : 3'h0};
      return full ? {2'h0, h, l} : {5'h0, h | l};
   endfunction
   function automatic logic [6:0] duty_of(input int lvl);
      if (lvl <= int'(LVL_ZERO)) return 7'h00;
      if (lvl >= int'(LVL_FULL)) return 7'h40;
      return 7'((lvl - int'(LVL_ZERO)) * PWM_DIV / int'(LVL_SPAN));
   endfunction

   always @(posedge clk) begin
      logic [63:0] m;
      if (psel && penable && pready === 1'b1 && !pwrite && rq.size() > 0) begin
         m = rq.pop_front();
         check(prdata & m[63:32], m[31:0]);
      end
      if (psamp === 1'b1) check({24'h0, sine_active, irq, gate_hi, gate_lo}, 32'(pq.pop_front()));
   end

   initial begin
      #200_000;
      n_errors++;
      complete_run;
   end

   // ----------------
   // main sequence
   // ----------------
   initial begin
      seed = 32'h9d27;
      {clk, psel, penable, pwrite, direction_select, angle_hit, psamp} = '0;
      {paddr, pwdata, speed_ref_pin, isense_cmd, step_cmd} = '0;
      srst = 1'b1;
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      wr(8'h40, 32'hFFFF_FFFF);
      foreach (RST_TAB[i]) rd(RST_TAB[i][39:32], 32'hFFFF_FFFF, RST_TAB[i][31:0]);
      rd(OFS_STATUS, 32'h0000_3FF8, 32'h0000_0808);
      pin(8'h00);
      wr(OFS_CTRL, 32'h7);
      wr(OFS_PWMMODE, 32'h1);
      rd(OFS_STATUS, 32'h0000_3800, 32'h0000_0800);
      for (int d = 0; d < 2; d++) begin
         for (int c = 0; c < 2; c++) begin
            for (int f = 0; f < 2; f++) begin
               direction_select <= d[0];
               wr(OFS_PWMMODE, 32'(c));
               wr(OFS_SPEED, f ? 32'hFF : 32'h0);
               repeat (80) @(posedge clk);
               for (int k = 1; k < 7; k++) begin
                  step_cmd <= 3'(k);
                  s = d ? 7 - k : k;
                  repeat (30) @(posedge clk);
                  pin(gexp(s, f[0], c[0]));
               end
               rd(OFS_STATUS, 32'h0000_3800, c ? 32'h0000_1000 : 32'h0000_0800);
            end
         end
      end
      wr(OFS_PWMMODE, 32'h0);
      foreach (LVLS[i]) begin
         wr(OFS_SPEED, 32'(LVLS[i]));
         repeat (80) @(posedge clk);
         rd(OFS_STATUS, 32'h0000_07F0, {21'h0, duty_of(LVLS[i]), 4'h0});
      end
      wr(OFS_SPEED, 32'hFF);
      foreach (TQ_T[i]) begin
         isense_cmd <= 8'(TQ_I[i]);
         wr(OFS_TORQUE, 32'(TQ_T[i]));
         wr(OFS_GAIN, 32'(TQ_G[i]));
         repeat (80) @(posedge clk);
         v = TQ_G[i] * (TQ_T[i] - TQ_I[i]);
         v = v < 0 ? 0 : (v > 255 ? 255 : v);
         rd(OFS_STATUS, 32'h0000_07F0, {21'h0, duty_of(v), 4'h0});
      end
      isense_cmd <= 8'h00;
      wr(OFS_TORQUE, 32'hFF);
      wr(OFS_GAIN, 32'h1);
      // speed from the pin with random levels
      wr(OFS_CTRL, 32'h6);
      repeat (4) begin
         v = $random(seed) & 255;
         speed_ref_pin <= 8'(v);
         repeat (80) @(posedge clk);
         rd(OFS_STATUS, 32'h0000_07F0, {21'h0, duty_of(v), 4'h0});
      end
      wr(OFS_CTRL, 32'h7);
      wr(OFS_SPEED, 32'h0);
      foreach (SN_V[i]) begin
         wr(OFS_VMOD, SN_V[i]);
         wr(OFS_PWMMODE, SN_P[i]);
         repeat (20) @(posedge clk);
         rd(OFS_STATUS, 32'h0000_3800, SN_E[i]);
         pin(SN_E[i][13] ? 8'h80 : gexp(s, 1'b0, 1'b0));
      end
      wr(OFS_VMOD, 32'h0);
      wr(OFS_PWMMODE, 32'h0);
      wr(OFS_CTRL, 32'h1);
      wr(OFS_SPEED, 32'h80);
      for (int a = 1; a >= 0; a--) begin
         angle_hit <= a[0];
         repeat (80) @(posedge clk);
         rd(OFS_STATUS, 32'h0000_3800, a ? 32'h0000_2000 : 32'h0000_0800);
      end
      // interrupts: hall fault raised, masked, cleared, then a step change
      wr(OFS_SPEED, 32'h0);
      step_cmd <= 3'h3;
      repeat (30) @(posedge clk);
      wr(OFS_IRQ_CLR, 32'h7);
      wr(OFS_IRQ_EN, 32'h1);
      step_cmd <= 3'h7;
      repeat (30) @(posedge clk);
      pin(8'h40);
      rd(OFS_IRQ_STAT, 32'h1, 32'h1);
      wr(OFS_IRQ_EN, 32'h0);
      pin(8'h00);
      wr(OFS_IRQ_CLR, 32'h1);
      wr(OFS_IRQ_EN, 32'h2);
      step_cmd <= 3'h1;
      repeat (30) @(posedge clk);
      wr(OFS_IRQ_STAT, 32'h0);
      pin(8'h40 | gexp(6, 1'b0, 1'b0));
      wr(OFS_IRQ_CLR, 32'h2);
      pin(gexp(6, 1'b0, 1'b0));
      rd(OFS_IRQ_STAT, 32'h2, 32'h0);
      wr(OFS_DEAD, 32'h14);
      rd(OFS_DEAD, 32'hFF, 32'h14);
      repeat (5) @(posedge clk);
      complete_run;
   end
endmodule
